// >>> hdl/psm_pkg.sv
// Constants, register map and encodings for the programmable stage combiner.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
package psm_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned PSM_CLK_PERIOD_PS = 5000;
	localparam int unsigned PSM_CYCLE_TIME_MS = 5;
	localparam int unsigned PSM_CYCLE_CLKS =
		(PSM_CYCLE_TIME_MS * 1000000) / (PSM_CLK_PERIOD_PS / 1000);

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] PSM_OFF_MODE = 12'h000;
	localparam logic [11:0] PSM_OFF_BEHAV = 12'h004;
	localparam logic [11:0] PSM_OFF_AVAIL = 12'h008;
	localparam logic [11:0] PSM_OFF_ENABLE = 12'h00C;
	localparam logic [11:0] PSM_OFF_FORCE = 12'h010;
	localparam logic [11:0] PSM_OFF_MEAS_CNT = 12'h014;
	localparam logic [11:0] PSM_OFF_HANDLING = 12'h018;
	localparam logic [11:0] PSM_OFF_CATEGORY = 12'h01C;
	localparam logic [11:0] PSM_OFF_SELECT = 12'h020;
	localparam logic [11:0] PSM_OFF_MULT0 = 12'h024;
	localparam logic [11:0] PSM_OFF_TERM = 12'h030;
	localparam logic [11:0] PSM_OFF_STATUS = 12'h034;
	localparam logic [11:0] PSM_OFF_COMBINED = 12'h038;
	localparam logic [11:0] PSM_OFF_GROUP0 = 12'h040;
	localparam logic [11:0] PSM_OFF_GROUP_END = 12'h0C0;

	// Field positions
	localparam int unsigned PSM_SEL_STRIDE = 8;
	localparam int unsigned PSM_ST_ACTIVE = 0;
	localparam int unsigned PSM_ST_START = 1;
	localparam int unsigned PSM_ST_TRIP = 2;
	localparam int unsigned PSM_ST_BLOCKED = 3;
	localparam int unsigned PSM_ST_DIVZERO = 4;
	localparam int unsigned PSM_ST_DISABLED = 5;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [3:0] PSM_OWN_INDEX = 4'h1;
	localparam logic [3:0] PSM_AVAIL_MIN = 4'h1;
	localparam logic [3:0] PSM_AVAIL_MAX = 4'hA;
	localparam logic [3:0] PSM_AVAIL_RST = 4'h1;
	localparam logic [23:0] PSM_MULT_RST = 24'h000001;
	localparam logic signed [23:0] PSM_MULT_MAX = 24'sh4C4B40;
	localparam logic signed [23:0] PSM_MULT_MIN = -24'sh4C4B40;
	localparam logic [2:0] PSM_CAT_MAX = 3'h4;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PSM_MODE_ON = 3'h1,
		PSM_MODE_BLOCKED = 3'h2,
		PSM_MODE_TEST = 3'h3,
		PSM_MODE_TEST_BLOCKED = 3'h4,
		PSM_MODE_OFF = 3'h5
	} psm_mode_t;

	localparam logic [1:0] PSM_FORCE_NORMAL = 2'h0;
	localparam logic [1:0] PSM_FORCE_START = 2'h1;
	localparam logic [1:0] PSM_FORCE_TRIP = 2'h2;
	localparam logic [1:0] PSM_FORCE_BLOCKED = 2'h3;

	localparam logic [1:0] PSM_CNT_ONE = 2'h0;
	localparam logic [1:0] PSM_CNT_TWO = 2'h1;
	localparam logic [1:0] PSM_CNT_THREE = 2'h2;

	localparam logic [1:0] PSM_TERM_OVER = 2'h0;
	localparam logic [1:0] PSM_TERM_UNDER = 2'h1;
	localparam logic [1:0] PSM_TERM_ROC = 2'h2;

endpackage

// >>> hdl/psm_stage.sv
// Programmable protection stage: operand capture, scaling, combining,
// pick-up terms, definite delay, mode and forcing, APB register slave.
// Assumes measurements arrive on the system clock from preprocessing.

module psm_stage
	import psm_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = PSM_CYCLE_CLKS
)
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic meas_valid_i,
	input wire logic [2:0] meas_cat_i,
	input wire logic [3:0] meas_idx_i,
	input wire logic [31:0] meas_value_i,
	input wire logic [2:0] active_group_i,
	output logic start_o,
	output logic trip_o,
	output logic blocked_o,
	output logic test_o,
	output logic cycle_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	psm_mode_t mode_q;
	logic [3:0] avail_q;
	logic enable_q;
	logic [1:0] force_q;
	logic [1:0] cnt_q;
	logic [2:0] handling_q;
	logic [2:0] category_q;
	logic [3:0] sel_q [3];
	logic signed [23:0] mult_q [3];
	logic [1:0] term_q;
	logic [31:0] bank_q [32];
	logic signed [31:0] raw_q [3];
	logic signed [31:0] scaled [3];
	logic signed [31:0] prev_op_q [3];
	logic signed [95:0] comb_d;
	logic signed [95:0] comb_q;
	logic comb_valid;
	logic div_zero;
	logic [2:0] op_hit;
	logic fulfilled_d;
	logic pick_q;
	logic trip_q;
	logic div_zero_q;
	logic [15:0] delay_cnt_q;
	logic [31:0] tick_cnt_q;
	logic tick;
	logic active;
	logic running;
	logic [31:0] pu [3];
	logic [15:0] delay_set;
	logic bus_access;
	logic bus_commit;
	logic wr_en;
	logic [31:0] rd_d;
	logic rd_err;
	logic [31:0] status;
	psm_mode_t behav;
	logic start_d;
	logic trip_d;
	logic blocked_d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Clamp a scaled product into 32 signed bits
	function automatic logic signed [31:0] sat32(input logic signed [55:0] v);
		logic signed [55:0] hi;
		logic signed [55:0] lo;
		hi = 56'sh0000007FFFFFFF;
		lo = -56'sh00000080000000;
		if (v > hi)
			sat32 = 32'sh7FFFFFFF;
		else if (v < lo)
			sat32 = 32'sh80000000;
		else
			sat32 = v[31:0];
	endfunction

	// One pick-up term against a threshold
	function automatic logic term_hit(input logic signed [95:0] v,
		input logic signed [95:0] p, input logic signed [31:0] thr,
		input logic [1:0] sel);
		logic signed [95:0] t;
		logic signed [95:0] dv;
		t = 96'(thr);
		dv = (v > p) ? (v - p) : (p - v);
		case (sel)
			PSM_TERM_OVER: term_hit = v > t;
			PSM_TERM_UNDER: term_hit = v < t;
			PSM_TERM_ROC: term_hit = dv > t;
			default: term_hit = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Processing cycle timer
	// ----------------------------------------------------------------
	assign tick = (tick_cnt_q == 32'(CYCLE_CLKS - 1));

	// Free-running 5 ms cycle counter
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tick_cnt_q <= 32'h00000000;
		else if (tick)
			tick_cnt_q <= 32'h00000000;
		else
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
	end

	// ----------------------------------------------------------------
	// Operand capture and scaling
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_op
			// Latch the chosen measurement of the chosen category
			always_ff @(posedge clock_i or posedge sys_rst_i)
			begin
				if (sys_rst_i)
					raw_q[gi] <= 32'sh00000000;
				else if (meas_valid_i && meas_cat_i == category_q
					&& meas_idx_i == sel_q[gi])
					raw_q[gi] <= meas_value_i;
			end
			assign scaled[gi] = sat32(56'(raw_q[gi]) * 56'(mult_q[gi]));
			assign pu[gi] = bank_q[{active_group_i, 2'(gi)}];
			assign op_hit[gi] = term_hit(96'(scaled[gi]), 96'(prev_op_q[gi]),
				pu[gi], term_q);
		end
	endgenerate

	assign delay_set = bank_q[{active_group_i, 2'h3}][15:0];

	// ----------------------------------------------------------------
	// Magnitude combination
	// ----------------------------------------------------------------
	// Arithmetic combined value and logical pick-up decision
	always_comb
	begin
		logic signed [95:0] a;
		logic signed [95:0] b;
		logic signed [95:0] c;
		a = 96'(scaled[0]);
		b = 96'(scaled[1]);
		c = 96'(scaled[2]);
		comb_d = a;
		comb_valid = 1'b1;
		div_zero = 1'b0;
		fulfilled_d = 1'b0;
		case (cnt_q)
			PSM_CNT_ONE: comb_d = a;
			PSM_CNT_TWO:
				case (handling_q)
					3'h0: comb_d = a * b;
					3'h1:
					begin
						div_zero = (scaled[1] == 32'sh00000000);
						comb_d = div_zero ? 96'sh0 : 96'(scaled[0] / scaled[1]);
					end
					3'h2: comb_d = (a > b) ? a : b;
					3'h3: comb_d = (a < b) ? a : b;
					3'h4:
					begin
						comb_valid = 1'b0;
						fulfilled_d = op_hit[0] | op_hit[1];
					end
					3'h5:
					begin
						comb_valid = 1'b0;
						fulfilled_d = op_hit[0] & op_hit[1];
					end
					3'h6: comb_d = a - b;
					default: comb_valid = 1'b0;
				endcase
			PSM_CNT_THREE:
				case (handling_q)
					3'h0: comb_d = a * b * c;
					3'h1: comb_d = (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
					3'h2: comb_d = (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
					3'h3:
					begin
						comb_valid = 1'b0;
						fulfilled_d = |op_hit;
					end
					3'h4:
					begin
						comb_valid = 1'b0;
						fulfilled_d = &op_hit;
					end
					3'h5:
					begin
						comb_valid = 1'b0;
						fulfilled_d = (op_hit[0] | op_hit[1]) & op_hit[2];
					end
					default: comb_valid = 1'b0;
				endcase
			default: comb_valid = 1'b0;
		endcase
		if (comb_valid && !div_zero)
			fulfilled_d = term_hit(comb_d, comb_q, pu[0], term_q);
	end

	// ----------------------------------------------------------------
	// Pick-up and definite delay, once per processing cycle
	// ----------------------------------------------------------------
	assign active = (PSM_OWN_INDEX <= avail_q);
	assign running = active && enable_q && mode_q != PSM_MODE_OFF;

	// Sample combined value and previous operands at each cycle tick
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			comb_q <= 96'sh0;
			div_zero_q <= 1'b0;
			for (int i = 0; i < 3; i++)
				prev_op_q[i] <= 32'sh00000000;
		end
		else if (tick)
		begin
			comb_q <= comb_d;
			div_zero_q <= div_zero;
			for (int i = 0; i < 3; i++)
				prev_op_q[i] <= scaled[i];
		end
	end

	// Pick-up state and delay count in processing cycles
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pick_q <= 1'b0;
			trip_q <= 1'b0;
			delay_cnt_q <= 16'h0000;
		end
		else if (!running)
		begin
			pick_q <= 1'b0;
			trip_q <= 1'b0;
			delay_cnt_q <= 16'h0000;
		end
		else if (tick)
		begin
			pick_q <= fulfilled_d;
			if (!fulfilled_d)
			begin
				trip_q <= 1'b0;
				delay_cnt_q <= 16'h0000;
			end
			else
			begin
				if (delay_cnt_q >= delay_set)
					trip_q <= 1'b1;
				if (delay_cnt_q != 16'hFFFF)
					delay_cnt_q <= delay_cnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode, forcing and outputs
	// ----------------------------------------------------------------
	// Effective output levels and reported behaviour
	always_comb
	begin
		behav = running ? mode_q : PSM_MODE_OFF;
		start_d = 1'b0;
		trip_d = 1'b0;
		blocked_d = 1'b0;
		if (running)
		begin
			case (force_q)
				PSM_FORCE_START: start_d = 1'b1;
				PSM_FORCE_TRIP:
				begin
					start_d = 1'b1;
					trip_d = 1'b1;
				end
				PSM_FORCE_BLOCKED: blocked_d = 1'b1;
				default:
					case (mode_q)
						PSM_MODE_ON, PSM_MODE_TEST:
						begin
							start_d = pick_q;
							trip_d = trip_q;
						end
						PSM_MODE_BLOCKED, PSM_MODE_TEST_BLOCKED: blocked_d = 1'b1;
						default: blocked_d = 1'b0;
					endcase
			endcase
		end
	end

	// Registered stage outputs
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			start_o <= 1'b0;
			trip_o <= 1'b0;
			blocked_o <= 1'b0;
			test_o <= 1'b0;
			cycle_o <= 1'b0;
		end
		else
		begin
			start_o <= start_d;
			trip_o <= trip_d;
			blocked_o <= blocked_d;
			test_o <= running && (mode_q == PSM_MODE_TEST
				|| mode_q == PSM_MODE_TEST_BLOCKED);
			cycle_o <= tick;
		end
	end

	// ----------------------------------------------------------------
	// APB slave: one wait state, write at the pready edge
	// ----------------------------------------------------------------
	assign bus_access = psel_i && penable_i;
	assign bus_commit = bus_access && pready_o;
	assign wr_en = bus_commit && pwrite_i && !pslverr_o;

	assign status = {26'h0, !enable_q || !active, div_zero_q, blocked_o, trip_o,
		start_o, running};

	// Read mux and unmapped decode
	always_comb
	begin
		rd_d = 32'h00000000;
		rd_err = 1'b0;
		if (paddr_i[1:0] != 2'h0)
			rd_err = 1'b1;
		else if (paddr_i >= PSM_OFF_GROUP0 && paddr_i < PSM_OFF_GROUP_END)
			rd_d = bank_q[5'(paddr_i[11:2] - PSM_OFF_GROUP0[11:2])];
		else
			case (paddr_i)
				PSM_OFF_MODE: rd_d = {29'h0, mode_q};
				PSM_OFF_BEHAV: rd_d = {29'h0, behav};
				PSM_OFF_AVAIL: rd_d = {28'h0, avail_q};
				PSM_OFF_ENABLE: rd_d = {31'h0, enable_q};
				PSM_OFF_FORCE: rd_d = {30'h0, force_q};
				PSM_OFF_MEAS_CNT: rd_d = {30'h0, cnt_q};
				PSM_OFF_HANDLING: rd_d = {29'h0, handling_q};
				PSM_OFF_CATEGORY: rd_d = {29'h0, category_q};
				PSM_OFF_SELECT: rd_d = {12'h0, sel_q[2], 4'h0, sel_q[1], 4'h0, sel_q[0]};
				PSM_OFF_MULT0: rd_d = 32'(mult_q[0]);
				PSM_OFF_MULT0 + 12'h004: rd_d = 32'(mult_q[1]);
				PSM_OFF_MULT0 + 12'h008: rd_d = 32'(mult_q[2]);
				PSM_OFF_TERM: rd_d = {30'h0, term_q};
				PSM_OFF_STATUS: rd_d = status;
				PSM_OFF_COMBINED: rd_d = sat32(comb_q[55:0]);
				default: rd_err = 1'b1;
			endcase
	end

	// Bus answer registers
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end
		else if (bus_access && !pready_o)
		begin
			pready_o <= 1'b1;
			pslverr_o <= rd_err;
			prdata_o <= (pwrite_i || rd_err) ? 32'h00000000 : rd_d;
		end
		else
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// General settings, independent of the active group
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			mode_q <= PSM_MODE_ON;
			avail_q <= PSM_AVAIL_RST;
			enable_q <= 1'b0;
			force_q <= PSM_FORCE_NORMAL;
			cnt_q <= PSM_CNT_ONE;
			handling_q <= 3'h0;
			category_q <= 3'h0;
			term_q <= PSM_TERM_OVER;
			for (int i = 0; i < 3; i++)
			begin
				sel_q[i] <= 4'h0;
				mult_q[i] <= PSM_MULT_RST;
			end
		end
		else if (wr_en)
		begin
			case (paddr_i)
				PSM_OFF_MODE:
					if (pwdata_i[2:0] >= 3'h1 && pwdata_i[2:0] <= 3'h5)
						mode_q <= psm_mode_t'(pwdata_i[2:0]);
				PSM_OFF_AVAIL:
					if (pwdata_i[3:0] >= PSM_AVAIL_MIN && pwdata_i[3:0] <= PSM_AVAIL_MAX)
						avail_q <= pwdata_i[3:0];
				PSM_OFF_ENABLE: enable_q <= pwdata_i[0];
				PSM_OFF_FORCE: force_q <= pwdata_i[1:0];
				PSM_OFF_MEAS_CNT:
					if (pwdata_i[1:0] != 2'h3)
						cnt_q <= pwdata_i[1:0];
				PSM_OFF_HANDLING: handling_q <= pwdata_i[2:0];
				PSM_OFF_CATEGORY:
					if (pwdata_i[2:0] <= PSM_CAT_MAX)
						category_q <= pwdata_i[2:0];
				PSM_OFF_SELECT:
					for (int i = 0; i < 3; i++)
						sel_q[i] <= pwdata_i[i * PSM_SEL_STRIDE +: 4];
				PSM_OFF_TERM:
					if (pwdata_i[1:0] != 2'h3)
						term_q <= pwdata_i[1:0];
				default:
					for (int i = 0; i < 3; i++)
						if (paddr_i == PSM_OFF_MULT0 + 12'(4 * i)
							&& $signed(pwdata_i) <= 32'(PSM_MULT_MAX)
							&& $signed(pwdata_i) >= 32'(PSM_MULT_MIN))
							mult_q[i] <= pwdata_i[23:0];
			endcase
		end
	end

	// Banked pick-up thresholds and delays, eight groups of four words
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < 32; i++)
				bank_q[i] <= 32'h00000000;
		end
		else if (wr_en && paddr_i >= PSM_OFF_GROUP0 && paddr_i < PSM_OFF_GROUP_END)
			bank_q[5'(paddr_i[11:2] - PSM_OFF_GROUP0[11:2])] <= pwdata_i;
	end

endmodule

// >>> test/psm_stage_asserts.sv
// Concurrent checks on the ports of the programmable stage.
// Assumes binding into psm_stage; single clock domain, async reset.
module psm_stage_asserts
	import psm_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = PSM_CYCLE_CLKS
)
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic start_o,
	input wire logic trip_o,
	input wire logic blocked_o,
	input wire logic cycle_o
);
	// ----------------------------------------------------------------
	// Tick spacing helper
	// ----------------------------------------------------------------
	logic [31:0] gap_q;
	logic seen_q;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// Clocks since the last tick pulse
	always_ff @(posedge clock_i or posedge sys_rst_i)
		if (sys_rst_i)
			gap_q <= 32'h0;
		else if (cycle_o)
			gap_q <= 32'h0;
		else
			gap_q <= gap_q + 32'h1;

	// First tick seen
	always_ff @(posedge clock_i or posedge sys_rst_i)
		if (sys_rst_i)
			seen_q <= 1'b0;
		else if (cycle_o)
			seen_q <= 1'b1;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_ready_wait: assert property (psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	a_idle_quiet: assert property (!psel_i |-> !pready_o)
		else $error("ready without select");
	a_err_align: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
		else $error("misaligned access not refused");
	a_err_range: assert property (pready_o && paddr_i >= PSM_OFF_GROUP_END |-> pslverr_o)
		else $error("unmapped access not refused");
	a_good_noerr: assert property (pready_o && paddr_i == PSM_OFF_MODE |-> !pslverr_o)
		else $error("mode access refused");
	a_err_data: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
		else $error("refused read returned data");
	a_trip_start: assert property (trip_o |-> start_o)
		else $error("trip without start");
	a_blocked_excl: assert property (blocked_o |-> !start_o && !trip_o)
		else $error("blocked with start or trip");
	a_reset_quiet: assert property ($fell(sys_rst_i) |-> !(start_o || trip_o || blocked_o))
		else $error("outputs active after reset");
	a_cycle_gap: assert property (cycle_o && seen_q |-> gap_q == CYCLE_CLKS - 1)
		else $error("tick spacing wrong");

	// Main scenarios reached
	c_refused: cover property (pready_o && pslverr_o);
	c_trip: cover property (trip_o);
	c_blocked: cover property (blocked_o);
	c_ticks: cover property (cycle_o && seen_q);
endmodule

bind psm_stage psm_stage_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) psm_stage_asserts_inst (
	.clock_i(clock_i),
	.sys_rst_i(sys_rst_i),
	.psel_i(psel_i),
	.penable_i(penable_i),
	.pwrite_i(pwrite_i),
	.paddr_i(paddr_i),
	.prdata_o(prdata_o),
	.pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.start_o(start_o),
	.trip_o(trip_o),
	.blocked_o(blocked_o),
	.cycle_o(cycle_o)
);

// >>> test/psm_meas_model.sv
// Measurement preprocessing chain feeding one word per strobe.
// Assumes the caller starts a send just after a rising edge.
module psm_meas_model
(
	input wire logic clock_i,
	output logic meas_valid_o,
	output logic [2:0] meas_cat_o,
	output logic [3:0] meas_idx_o,
	output logic [31:0] meas_value_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial
	begin
		meas_valid_o = 1'b0;
		meas_cat_o = 3'h7;
		meas_idx_o = 4'hF;
		meas_value_o = 32'hA5A5A5A5;
	end

	// One strobed word, then the value line shows the inverse
	task send(input logic [2:0] c, input logic [3:0] i, input logic [31:0] v);
		@(posedge clock_i);
		meas_valid_o <= 1'b1;
		meas_cat_o <= c;
		meas_idx_o <= i;
		meas_value_o <= v;
		@(posedge clock_i);
		meas_valid_o <= 1'b0;
		meas_value_o <= ~v;
	endtask
endmodule

// >>> test/psm_stage_tb_top.sv
// Self-checking bench for the programmable stage over APB.
// Assumes the measurement model and checker are compiled alongside.
module psm_stage_tb_top
	import psm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned CYC = 20;
	logic clock_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, meas_value_i, r;
	logic meas_valid_i, start_o, trip_o, blocked_o, test_o, cycle_o, e;
	logic [2:0] meas_cat_i, active_group_i;
	logic [3:0] meas_idx_i;
	int n_fail, check_count, n;

	psm_stage #(.CYCLE_CLKS(CYC)) psm_stage_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.meas_valid_i(meas_valid_i), .meas_cat_i(meas_cat_i), .meas_idx_i(meas_idx_i),
		.meas_value_i(meas_value_i), .active_group_i(active_group_i), .start_o(start_o),
		.trip_o(trip_o), .blocked_o(blocked_o), .test_o(test_o), .cycle_o(cycle_o));
	psm_meas_model psm_meas_model_inst (.clock_i(clock_i), .meas_valid_o(meas_valid_i),
		.meas_cat_o(meas_cat_i), .meas_idx_o(meas_idx_i), .meas_value_o(meas_value_i));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		$display("mismatches=%0d comparisons=%0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1 && ++k < 50);
		if (k >= 50)
			n_fail++;
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask

	task settle(input int k);
		int t;
		repeat (k)
		begin
			t = 0;
			do @(posedge clock_i); while (cycle_o !== 1'b1 && ++t < 4 * CYC);
			if (t >= 4 * CYC)
				n_fail++;
		end
		repeat (2) @(posedge clock_i);
	endtask

	task run_case(input logic [1:0] c, input logic [2:0] h, input logic [31:0] b,
		input logic [31:0] comb, input logic use_c, input logic st);
		wr(PSM_OFF_MEAS_CNT, {30'h0, c});
		wr(PSM_OFF_HANDLING, {29'h0, h});
		psm_meas_model_inst.send(3'h1, 4'h0, 32'h3);
		psm_meas_model_inst.send(3'h1, 4'h1, b);
		psm_meas_model_inst.send(3'h1, 4'h2, 32'h5);
		psm_meas_model_inst.send(3'h0, 4'h0, 32'h7);
		settle(2);
		if (use_c)
			rd(PSM_OFF_COMBINED, comb);
		chk({31'h0, start_o}, {31'h0, st});
	endtask

	// Clock
	initial
	begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Watchdog
	initial
	begin
		repeat (60000) @(posedge clock_i);
		n_fail++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{sys_rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
		paddr_i = 12'h0;
		pwdata_i = 32'h0;
		active_group_i = 3'h0;
		n_fail = 0;
		check_count = 0;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		rd(PSM_OFF_MODE, 32'h1);
		rd(PSM_OFF_BEHAV, 32'h5);
		rd(PSM_OFF_AVAIL, 32'h1);
		rd(PSM_OFF_ENABLE, 32'h0);
		rd(PSM_OFF_FORCE, 32'h0);
		rd(PSM_OFF_MULT0 + 12'h8, 32'h1);
		rd(12'h0C0, 32'h0);
		chk({31'h0, e}, 32'h1);
		rd(12'h002, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(PSM_OFF_MODE, 32'h6);
		rd(PSM_OFF_MODE, 32'h1);
		wr(PSM_OFF_BEHAV, 32'h3);
		rd(PSM_OFF_BEHAV, 32'h5);
		wr(PSM_OFF_AVAIL, 32'hA);
		wr(PSM_OFF_AVAIL, 32'hB);
		rd(PSM_OFF_AVAIL, 32'hA);
		for (n = 0; n < 6; n++)
		begin
			wr(PSM_OFF_CATEGORY, n);
			rd(PSM_OFF_CATEGORY, n > 4 ? 4 : n);
		end
		wr(PSM_OFF_MULT0 + 12'h4, 32'hFFFFFFFF);
		rd(PSM_OFF_MULT0 + 12'h4, 32'hFFFFFFFF);
		wr(PSM_OFF_MULT0 + 12'h4, 32'h00FFFFFF);
		rd(PSM_OFF_MULT0 + 12'h4, 32'hFFFFFFFF);
		wr(PSM_OFF_MULT0 + 12'h4, 32'h1);
		wr(PSM_OFF_CATEGORY, 32'h1);
		wr(PSM_OFF_SELECT, 32'h00020100);
		wr(PSM_OFF_MULT0, 32'h2);
		wr(PSM_OFF_GROUP0, 32'h5);
		wr(PSM_OFF_GROUP0 + 12'h4, 32'h5);
		wr(PSM_OFF_GROUP0 + 12'h8, 32'h4);
		wr(PSM_OFF_ENABLE, 32'h1);
		rd(PSM_OFF_BEHAV, 32'h1);
		run_case(2'h0, 3'h0, 32'h2, 32'h6, 1'b1, 1'b1);
		run_case(2'h1, 3'h0, 32'h2, 32'hC, 1'b1, 1'b1);
		run_case(2'h1, 3'h1, 32'h2, 32'h3, 1'b1, 1'b0);
		run_case(2'h1, 3'h2, 32'h2, 32'h6, 1'b1, 1'b1);
		run_case(2'h1, 3'h3, 32'h2, 32'h2, 1'b1, 1'b0);
		run_case(2'h1, 3'h4, 32'h2, 32'h0, 1'b0, 1'b1);
		run_case(2'h1, 3'h5, 32'h2, 32'h0, 1'b0, 1'b0);
		run_case(2'h1, 3'h6, 32'h2, 32'h4, 1'b1, 1'b0);
		run_case(2'h2, 3'h0, 32'h2, 32'h3C, 1'b1, 1'b1);
		run_case(2'h2, 3'h1, 32'h2, 32'h6, 1'b1, 1'b1);
		run_case(2'h2, 3'h2, 32'h2, 32'h2, 1'b1, 1'b0);
		run_case(2'h2, 3'h3, 32'h2, 32'h0, 1'b0, 1'b1);
		run_case(2'h2, 3'h4, 32'h2, 32'h0, 1'b0, 1'b0);
		run_case(2'h2, 3'h5, 32'h2, 32'h0, 1'b0, 1'b1);
		run_case(2'h1, 3'h1, 32'h0, 32'h0, 1'b0, 1'b0);
		rd(PSM_OFF_STATUS, 32'h11);
		// Definite delay of two ticks on max of operands
		wr(PSM_OFF_GROUP0, 32'h64);
		wr(PSM_OFF_GROUP0 + 12'hC, 32'h2);
		run_case(2'h1, 3'h2, 32'h2, 32'h6, 1'b1, 1'b0);
		wr(PSM_OFF_GROUP0, 32'h5);
		n = 0;
		while (trip_o !== 1'b1 && n < 10)
		begin
			settle(1);
			if (start_o === 1'b1)
				n++;
		end
		chk(n, 32'h3);
		wr(PSM_OFF_MODE, 32'h2);
		settle(2);
		chk({blocked_o, trip_o, start_o}, 32'h4);
		wr(PSM_OFF_MODE, 32'h4);
		settle(2);
		rd(PSM_OFF_BEHAV, 32'h4);
		chk({test_o, blocked_o}, 32'h3);
		wr(PSM_OFF_MODE, 32'h1);
		wr(PSM_OFF_GROUP0, 32'h64);
		for (n = 0; n < 4; n++)
		begin
			wr(PSM_OFF_FORCE, n);
			settle(2);
			chk({blocked_o, trip_o, start_o}, n == 0 ? 0 : n == 1 ? 1 : n == 2 ? 3 : 4);
		end
		wr(PSM_OFF_FORCE, 32'h1);
		wr(PSM_OFF_MODE, 32'h5);
		settle(2);
		rd(PSM_OFF_BEHAV, 32'h5);
		chk({blocked_o, trip_o, start_o}, 32'h0);
		active_group_i <= 3'h1;
		rd(PSM_OFF_MODE, 32'h5);
		rd(PSM_OFF_FORCE, 32'h1);
		rd(PSM_OFF_MEAS_CNT, 32'h1);
		wr(PSM_OFF_MODE, 32'h1);
		wr(PSM_OFF_ENABLE, 32'h0);
		settle(1);
		rd(PSM_OFF_STATUS, 32'h20);
		print_verdict();
	end
endmodule
